// ==== design/alias_decoder.sv ====
/*
 One alias decoder: flags a local address that equals a programmed alias.
 Assumes the alias register layout of the remap package; purely combinational.
*/
`timescale 1ns/10ps
module alias_decoder
	import remap_pkg::*;
(
	input  wire logic [REG_W-1:0] aliasReg,
	input  wire logic [I2C_W-1:0] addr,
	output logic                  hit
);
	// A zero alias field switches the slot off entirely
	assign hit = (aliasReg[ADDR_HI:ADDR_LO] != ALIAS_OFF) //RULE3
		&& (aliasReg[ADDR_HI:ADDR_LO] == addr); //RULE2
endmodule

// ==== design/i2c_remote_alias_remap.sv ====
/*
 Remote alias remap: APB register file for physical and alias addresses,
 per-slot alias decode, address substitution towards the control channel
 and local acknowledge handling, including the debug auto-acknowledge.
 Assumes the local I2C front end and the control channel run on clk and
 present address phases and remote acknowledges as one-cycle strobes.
*/
// The APB register port was decided locally.
// Functional notes
// RULE1: Replace matched alias with slot physical address
// RULE2: Compare local address with each slot alias
// RULE3: Zero alias disables the slot
// RULE4: Auto-ack bit acknowledges writes locally
// RULE5: Software keeps auto-ack for debugging only
// RULE6: Otherwise stretch, then return remote ACK/NACK
`timescale 1ns/10ps
module i2c_remote_alias_remap
	import remap_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       rstn,
	input  wire logic [remap_pkg::ADDR_W-1:0] paddr,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [remap_pkg::DATA_W-1:0] pwdata,
	output logic      [remap_pkg::DATA_W-1:0] prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       reqValid,
	input  wire logic [remap_pkg::I2C_W-1:0] reqAddr,
	input  wire logic                       reqRead,
	output logic                            reqReady,
	output logic                            fwdValid,
	output logic      [remap_pkg::I2C_W-1:0] fwdAddr,
	output logic                            fwdRead,
	input  wire logic                       remAckValid,
	input  wire logic                       remAck,
	output logic                            ansValid,
	output logic                            ansAck,
	output logic                            stretch
);
	import remap_pkg::*;

	logic [REG_W-1:0]  physDec   [NUM_SLOTS];
	logic [REG_W-1:0]  aliasAddr [NUM_SLOTS];
	logic [REG_W-1:0]  physStore [NUM_STORE];
	logic [REG_W-1:0]  next_physDec   [NUM_SLOTS];
	logic [REG_W-1:0]  next_aliasAddr [NUM_SLOTS];
	logic [REG_W-1:0]  next_physStore [NUM_STORE];
	logic [DATA_W-1:0] next_prdata;
	logic              next_pready;
	logic              next_pslverr;

	// APB register file: answers one cycle after setup, no wait states
	always_comb
	begin
		next_physDec   = physDec;
		next_aliasAddr = aliasAddr;
		next_physStore = physStore;
		next_prdata    = prdata;
		next_pslverr   = pslverr;
		next_pready    = 1'b0;
		if (psel && !penable)
		begin
			next_pready  = 1'b1;
			next_pslverr = 1'b1;   // Unmapped until a decode below hits
			next_prdata  = '0;
			for (int i = 0; i < NUM_SLOTS; i++)
			begin
				if (paddr == OFS_PHYS_DEC[i])
				begin
					next_pslverr = 1'b0;
					next_prdata  = {RD_PAD, physDec[i]};
				end
				if (paddr == OFS_ALIAS[i])
				begin
					next_pslverr = 1'b0;
					next_prdata  = {RD_PAD, aliasAddr[i]};
				end
			end
			for (int j = 0; j < NUM_STORE; j++)
			begin
				if (paddr == OFS_PHYS_STORE[j])
				begin
					next_pslverr = 1'b0;
					next_prdata  = {RD_PAD, physStore[j]};
				end
			end
		end
		// Writes land only at the completing access edge
		if (psel && penable && pready && pwrite)
		begin
			for (int i = 0; i < NUM_SLOTS; i++)
			begin
				if (paddr == OFS_PHYS_DEC[i])
					next_physDec[i] = {pwdata[ADDR_HI:ADDR_LO], 1'b0}; //RULE1
				if (paddr == OFS_ALIAS[i])
					next_aliasAddr[i] = pwdata[REG_W-1:0]; //RULE2
			end
			for (int j = 0; j < NUM_STORE; j++)
			begin
				if (paddr == OFS_PHYS_STORE[j])
					next_physStore[j] = {pwdata[ADDR_HI:ADDR_LO], 1'b0}; //RULE1
			end
		end
	end

	// Register file state
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NUM_SLOTS; i++)
			begin
				physDec[i]   <= REG_RESET;
				aliasAddr[i] <= REG_RESET;
			end
			for (int j = 0; j < NUM_STORE; j++)
				physStore[j] <= REG_RESET;
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			physDec   <= next_physDec;
			aliasAddr <= next_aliasAddr;
			physStore <= next_physStore;
			prdata    <= next_prdata;
			pready    <= next_pready;
			pslverr   <= next_pslverr;
		end
	end

	logic [NUM_SLOTS-1:0] hit;
	logic                 anyHit;
	logic                 selSlot;

	// One decoder per alias slot
	for (genvar g = 0; g < NUM_SLOTS; g++)
	begin : gDec
		alias_decoder uDec
		(
			.aliasReg (aliasAddr[g]),
			.addr     (reqAddr),
			.hit      (hit[g])
		);
	end

	// Lowest slot wins if two aliases are programmed alike
	assign anyHit  = |hit;
	assign selSlot = !hit[0]; //RULE2

	remap_state_e         state;
	remap_state_e         next_state;
	logic                 autoDone;
	logic                 next_autoDone;
	logic                 next_reqReady;
	logic                 next_fwdValid;
	logic [I2C_W-1:0]     next_fwdAddr;
	logic                 next_fwdRead;
	logic                 next_ansValid;
	logic                 next_ansAck;
	logic                 next_stretch;

	// Remap sequencer; one transaction in flight, new ones held off
	always_comb
	begin
		next_state    = state;
		next_autoDone = autoDone;
		next_reqReady = reqReady;
		next_fwdValid = 1'b0;
		next_fwdAddr  = fwdAddr;
		next_fwdRead  = fwdRead;
		next_ansValid = 1'b0;
		next_ansAck   = ansAck;
		next_stretch  = stretch;
		case (state)
			ST_IDLE:
			begin
				// Unmatched addresses are not ours and get no answer
				if (reqValid && anyHit) //RULE3
				begin
					next_fwdValid = 1'b1;
					next_fwdAddr  = physDec[selSlot][ADDR_HI:ADDR_LO]; //RULE1
					next_fwdRead  = reqRead;
					next_reqReady = 1'b0;
					next_state    = ST_WAIT;
					if (aliasAddr[selSlot][AUTOACK_BIT] && !reqRead)
					begin
						// Debug path: ack now, remote result discarded
						next_ansValid = 1'b1; //RULE4
						next_ansAck   = 1'b1; //RULE4
						next_stretch  = 1'b0;
						next_autoDone = 1'b1;
					end
					else
					begin
						next_stretch  = 1'b1; //RULE6
						next_autoDone = 1'b0;
					end
				end
			end
			ST_WAIT:
			begin
				if (remAckValid)
				begin
					next_state    = ST_IDLE;
					next_reqReady = 1'b1;
					next_stretch  = 1'b0;
					if (!autoDone)
					begin
						next_ansValid = 1'b1; //RULE6
						next_ansAck   = remAck; //RULE6
					end
				end
			end
			default:
			begin
				next_state    = ST_IDLE;
				next_reqReady = 1'b1;
				next_stretch  = 1'b0;
			end
		endcase
	end

	// Sequencer state and registered outputs
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			state    <= ST_IDLE;
			autoDone <= 1'b0;
			reqReady <= 1'b1;
			fwdValid <= 1'b0;
			fwdAddr  <= ALIAS_OFF;
			fwdRead  <= 1'b0;
			ansValid <= 1'b0;
			ansAck   <= 1'b0;
			stretch  <= 1'b0;
		end
		else
		begin
			state    <= next_state;
			autoDone <= next_autoDone;
			reqReady <= next_reqReady;
			fwdValid <= next_fwdValid;
			fwdAddr  <= next_fwdAddr;
			fwdRead  <= next_fwdRead;
			ansValid <= next_ansValid;
			ansAck   <= next_ansAck;
			stretch  <= next_stretch;
		end
	end

endmodule

// ==== design/remap_pkg.sv ====
/*
 Shared constants for the remote alias remap block: register indices and
 byte offsets, field positions, reset values and the remap state type.
 Assumes a 32-bit APB slave with one aligned word per register.
*/
package remap_pkg;

	localparam int ADDR_W    = 12;    // APB byte address width
	localparam int DATA_W    = 32;
	localparam int REG_W     = 8;
	localparam int I2C_W     = 7;     // 7-bit I2C address
	localparam int NUM_SLOTS = 2;     // Slots with alias decode
	localparam int NUM_STORE = 3;     // Physical slots 5 to 7

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_PHYS0  = 8'h39;
	localparam logic [7:0] IDX_PHYS1  = 8'h3A;
	localparam logic [7:0] IDX_PHYS5  = 8'h3E;
	localparam logic [7:0] IDX_PHYS6  = 8'h3F;
	localparam logic [7:0] IDX_PHYS7  = 8'h40;
	localparam logic [7:0] IDX_ALIAS0 = 8'h41;
	localparam logic [7:0] IDX_ALIAS1 = 8'h42;

	localparam logic [ADDR_W-1:0] OFS_PHYS_DEC [NUM_SLOTS] =
		'{{2'h0, IDX_PHYS0, 2'h0}, {2'h0, IDX_PHYS1, 2'h0}};
	localparam logic [ADDR_W-1:0] OFS_ALIAS [NUM_SLOTS] =
		'{{2'h0, IDX_ALIAS0, 2'h0}, {2'h0, IDX_ALIAS1, 2'h0}};
	localparam logic [ADDR_W-1:0] OFS_PHYS_STORE [NUM_STORE] =
		'{{2'h0, IDX_PHYS5, 2'h0}, {2'h0, IDX_PHYS6, 2'h0}, {2'h0, IDX_PHYS7, 2'h0}};

	// Field layout and reset values
	localparam int ADDR_HI     = 7;
	localparam int ADDR_LO     = 1;
	localparam int AUTOACK_BIT = 0;
	localparam logic [REG_W-1:0]  REG_RESET   = 8'h00;
	localparam logic [I2C_W-1:0]  ALIAS_OFF   = 7'h00;
	localparam logic [DATA_W-REG_W-1:0] RD_PAD = 24'h000000;

	typedef enum {ST_IDLE, ST_WAIT} remap_state_e;

endpackage

// ==== verif/remap_chk.sv ====
/* Checker for the remap block, watching its local and forward ports.
 Assumes a bind onto the top module; one clock, synchronous reset. */
`timescale 1ns/10ps
module remap_chk
(
	input wire logic                        clk,
	input wire logic                        rstn,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic                        pready,
	input wire logic                        reqValid,
	input wire logic [remap_pkg::I2C_W-1:0] reqAddr,
	input wire logic                        reqRead,
	input wire logic                        reqReady,
	input wire logic                        fwdValid,
	input wire logic                        fwdRead,
	input wire logic                        remAckValid,
	input wire logic                        remAck,
	input wire logic                        ansValid,
	input wire logic                        ansAck,
	input wire logic                        stretch
);
	// One domain, so one clocking and reset for all
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_take; reqValid && reqReady; endsequence
	sequence s_wait; fwdValid && !ansValid; endsequence
	property p_fwd; fwdValid |-> $past(reqValid && reqReady); endproperty
	a_fwd: assert property (p_fwd) else $error("forward without request");
	property p_zero; reqValid && reqReady && reqAddr == 7'h00 |=> !fwdValid; endproperty
	a_zero: assert property (p_zero) else $error("zero alias forwarded");
	property p_rd; s_take ##1 fwdValid |-> fwdRead == $past(reqRead); endproperty
	a_rd: assert property (p_rd) else $error("direction lost");
	property p_hold; s_wait |-> stretch && !reqReady; endproperty
	a_hold: assert property (p_hold) else $error("no stretch");
	// Answer must wait for the remote, then carry its value
	property p_quiet; stretch && !remAckValid |=> stretch && !ansValid; endproperty
	a_quiet: assert property (p_quiet) else $error("early answer");
	property p_ans; stretch && remAckValid |=> ansValid && ansAck == $past(remAck); endproperty
	a_ans: assert property (p_ans) else $error("remote ack lost");
	property p_auto; fwdValid && ansValid |-> ansAck && !fwdRead; endproperty
	a_auto: assert property (p_auto) else $error("bad local ack");
	// Zero-wait register bus: pready in the access cycle only
	property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
	a_rdy: assert property (p_rdy) else $error("no access answer");
endmodule

// ==== verif/remote_model.sv ====
/* Far side: control channel returning the remote acknowledge.
 Assumes one forward at a time; delay and ack value come from the bench. */
`timescale 1ns/10ps
module remote_model
(
	input  wire logic       clk,
	input  wire logic       fwdValid,
	input  wire logic [3:0] delay,
	input  wire logic       ackVal,
	output logic            remAckValid,
	output logic            remAck
);
	int cnt = -1;
	initial {remAckValid, remAck} = 2'b00;
	// Answer after the delay; ack line toggles when not valid, no stale value
	// Each branch drives every output once, so no signal is assigned twice
	always @(posedge clk)
	begin
		if (fwdValid)
		begin
			cnt <= int'(delay);
			remAckValid <= 1'b0;
			remAck <= ~remAck;
		end
		else if (cnt == 0)
		begin
			cnt <= -1;
			remAckValid <= 1'b1;
			remAck <= ackVal;
		end
		else
		begin
			if (cnt > 0)
				cnt <= cnt - 1;
			remAckValid <= 1'b0;
			remAck <= ~remAck;
		end
	end
endmodule

// ==== verif/test_i2c_remote_alias_remap.sv ====
/* Bench: APB master, local requester and reference model of the remap.
 Assumes the remote model answers every forward; 50 MHz clock. */
`timescale 1ns/10ps
module test_i2c_remote_alias_remap;
	import remap_pkg::*;
	logic              clk, rstn, psel, penable, pwrite, pready, pslverr, e;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, r;
	logic              reqValid, reqRead, reqReady, fwdValid, fwdRead, ackVal;
	logic              remAckValid, remAck, ansValid, ansAck, stretch;
	logic [I2C_W-1:0]  reqAddr, fwdAddr, a;
	logic [3:0]        delay;
	logic [7:0]        m [7];
	logic [11:0]       ofs [7] = '{12'h0E4, 12'h0E8, 12'h0F8, 12'h0FC, 12'h100, 12'h104, 12'h108};
	int                seed = 67148, error_cnt = 0, cmp_count = 0, cyc = 0, n, k, j;
	i2c_remote_alias_remap dut (.clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .reqValid, .reqAddr, .reqRead, .reqReady, .fwdValid,
		.fwdAddr, .fwdRead, .remAckValid, .remAck, .ansValid, .ansAck, .stretch);
	remote_model peer (.clk, .fwdValid, .delay, .ackVal, .remAckValid, .remAck);
	initial
	begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	// Ceiling far above the planned run
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic chk(input logic ok, input string s);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t %s", $time, s);
		end
	endtask
	task automatic end_of_test();
		$display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] ad, input logic [7:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= {24'($random(seed)), d};
		@(posedge clk);
		penable <= 1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input int i, input logic [7:0] d);
		apb(1'b1, ofs[i], d);
		m[i] = i < 5 ? d & 8'hFE : d;
		chk(e === 1'b0, "write");
	endtask
	task automatic rdc(input int i);
		apb(1'b0, ofs[i], 8'h00);
		chk(r === {24'h0, m[i]} && e === 1'b0, "read");
	endtask
	// One local request; slot 0 wins a double match
	task automatic xfer(input logic [6:0] ad, input logic rd);
		int s, i;
		logic fw, an, ex, au;
		s = -1;
		fw = 0;
		an = 0;
		ex = 1'($random(seed));
		for (i = 1; i >= 0; i--)
			if (ad != 0 && m[5+i][7:1] == ad)
				s = i;
		au = s >= 0 && m[5+s][0] && !rd;
		@(posedge clk);
		while (reqReady !== 1'b1)
			@(posedge clk);
		reqValid <= 1;
		reqAddr <= ad;
		reqRead <= rd;
		ackVal <= ex;
		delay <= 4'($unsigned($random(seed)) % 8);
		@(posedge clk);
		reqValid <= 0;
		for (i = 0; i < 24 && !an; i++)
		begin
			@(posedge clk);
			if (fwdValid === 1'b1)
			begin
				fw = 1;
				chk(fwdAddr === m[s][7:1] && fwdRead === rd, "remap");
				if (au)
					chk(ansValid === 1'b1, "auto");
			end
			if (ansValid === 1'b1)
			begin
				an = 1;
				chk(ansAck === (au | ex), "answer");
			end
		end
		chk(fw === (s >= 0) && an === (s >= 0), "presence");
	endtask
	initial
	begin
		{rstn, psel, penable, pwrite, reqValid, reqRead, ackVal} = 0;
		paddr = 0;
		pwdata = 0;
		reqAddr = 0;
		delay = 0;
		m = '{default: 8'h00};
		repeat (10) @(posedge clk);
		rstn <= 1;
		// Reset values first, then random fill
		for (k = 0; k < 7; k++)
			rdc(k);
		for (n = 0; n < 2; n++)
			for (k = 0; k < 7; k++)
			begin
				wr(k, 8'($random(seed)));
				rdc(k);
			end
		apb(1'b1, 12'h200, 8'hFF);
		chk(e === 1'b1, "unmapped write");
		apb(1'b0, 12'h200, 8'h00);
		chk(e === 1'b1 && r === 32'h0, "unmapped read");
		// Auto-ack bit random here only as a debug exercise
		for (n = 0; n < 60; n++)
		begin
			if (n % 12 == 0)
				wr(5 + n / 12 % 2, n == 24 ? 8'h01 : 8'($random(seed)));
			if (n % 6 == 3)
				wr(n / 6 % 2, 8'($random(seed)));
			j = $unsigned($random(seed)) % 4;
			a = j < 2 ? m[5+j][7:1] : (j == 2 ? 7'($random(seed)) : 7'h00);
			xfer(a, 1'($random(seed)));
		end
		end_of_test();
	end
endmodule
bind i2c_remote_alias_remap remap_chk chk (.clk, .rstn, .psel, .penable, .pready,
	.reqValid, .reqAddr, .reqRead,
	.reqReady, .fwdValid, .fwdRead, .remAckValid, .remAck, .ansValid, .ansAck, .stretch);
